// ---- rtl/swl_top.sv ----
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// R1: Bits 4:2 of wake_logic_select choose one of six wake logic modes.
// R2: Source field zero selects nothing and never raises a recovery event.
// R3: Selected logic output equal to level bit 6 raises a recovery event.
// R4: Level 0 wakes on low result, level 1 wakes on high result.
// R5: Output pins and pins claimed by port 2/3 selectors are ignored.
// R6: Port 2 wake pin selector survives stop mode recovery.
// R7: Software writes 0 to reserved bit 7 and ignores its read value.
// R8: Any selected recovery source, here or elsewhere, ends stop mode.
// R9: Modes include NAND/NOR groups, one is NOR of three port 3 and two port 0 pins.
// R10: Power-on reset clears level and source; recovery leaves them unchanged.
module swl_top
   import swl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic [7:0]  p0_in,
   input  wire logic [7:0]  p2_in,
   input  wire logic [3:0]  p3_in,
   input  wire logic [7:0]  p0_out_en,
   input  wire logic [7:0]  p2_out_en,
   input  wire logic [3:0]  p3_out_en,
   input  wire logic        stop_req,
   input  wire logic        other_wake,
   output logic             stop_mode,
   output logic             recovery,
   output logic             irq
);
   logic [2:0]  src;
   logic        level;
   logic [7:0]  p2_sel;
   logic [3:0]  p3_sel;
   logic [1:0]  status;
   logic [1:0]  irq_en;
   logic        hit;
   logic        logic_prev;
   swl_state_t  state;
   swl_state_t  next_state;

   // Address decode
   wire logic wr_select = reg_wr && (reg_addr == SWL_ADDR_SELECT);
   wire logic wr_clear  = reg_wr && (reg_addr == SWL_ADDR_CLEAR);
   wire logic wr_enable = reg_wr && (reg_addr == SWL_ADDR_ENABLE);
   wire logic wr_p2sel  = reg_wr && (reg_addr == SWL_ADDR_CTRL);
   wire logic wr_p3sel  = reg_wr && (reg_addr == SWL_ADDR_PORT3);

   // Reserved bit 7 is dropped, so software's value there has no effect
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         src   <= SWL_SRC_RESET;     // R10
         level <= SWL_LEVEL_RESET;   // R10
      end else if (wr_select) begin
         src   <= reg_wdata[SWL_SRC_HI:SWL_SRC_LO];   // R1
         level <= reg_wdata[SWL_LEVEL_BIT];           // R4
      end
   end

   // Selectors reset only on power-on; recovery never touches them
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         p2_sel <= SWL_P2SEL_RESET;   // R6
         p3_sel <= SWL_P3SEL_RESET;
      end else begin
         if (wr_p2sel) begin
            p2_sel <= reg_wdata;      // R6
         end
         if (wr_p3sel) begin
            p3_sel <= reg_wdata[3:0];
         end
      end
   end

   swl_eval u_eval (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .src       (src),
      .level     (level),
      .p0_in     (p0_in),
      .p2_in     (p2_in),
      .p3_in     (p3_in),
      .p0_out_en (p0_out_en),
      .p2_out_en (p2_out_en),
      .p3_out_en (p3_out_en),
      .p2_sel    (p2_sel),
      .p3_sel    (p3_sel),
      .hit       (hit)
   );

   // Any source ends stop; only counts while stopped
   wire logic any_wake = hit | other_wake;   // R8

   // Next state; a wake request only counts while stopped
   always_comb begin
      next_state = state;
      case (state)
         SWL_RUN:  if (stop_req) next_state = SWL_STOP;
         SWL_STOP: if (any_wake) next_state = SWL_WAKE;   // R8
         SWL_WAKE: next_state = SWL_RUN;
         default:  next_state = SWL_RUN;
      endcase
   end

   // State register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= SWL_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Registered stop and recovery pulse outputs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         stop_mode <= 1'b0;
         recovery  <= 1'b0;
      end else begin
         stop_mode <= (next_state == SWL_STOP);
         recovery  <= (state == SWL_STOP) && any_wake;   // R8
      end
   end

   // Sticky status; an event in the clear cycle wins
   wire logic ev_wake  = (state == SWL_STOP) && any_wake;
   wire logic ev_logic = hit && !logic_prev;
   wire logic [1:0] ev = {ev_logic, ev_wake};
   wire logic [1:0] clr = wr_clear ? reg_wdata[1:0] : 2'h0;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         status     <= SWL_STAT_RESET;
         irq_en     <= SWL_STAT_RESET;
         logic_prev <= 1'b0;
      end else begin
         status     <= (status & ~clr) | ev;
         logic_prev <= hit;
         if (wr_enable) begin
            irq_en <= reg_wdata[1:0];
         end
      end
   end

   // Built from the next status, so a same-cycle event is not a cycle late
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((status & ~clr) | ev) & (wr_enable ? reg_wdata[1:0] : irq_en));
      end
   end

   // Read mux; write-only registers and unmapped addresses read zero
   wire logic [7:0] rd_mux =
      (reg_addr == SWL_ADDR_STATUS) ? {6'h00, status} :
      (reg_addr == SWL_ADDR_ENABLE) ? {6'h00, irq_en} : 8'h00;

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Checks
   a_zero_no_hit: assert property (@(posedge mclk) disable iff (sys_rst)   // R2
      (src == 3'h0) |=> !hit)
      else $error("hit with source zero");
   a_src_capture: assert property (@(posedge mclk) disable iff (sys_rst)   // R1
      wr_select |=> (src == $past(reg_wdata[4:2])))
      else $error("source field not captured");
   a_level_capture: assert property (@(posedge mclk) disable iff (sys_rst)   // R4
      wr_select |=> (level == $past(reg_wdata[6])))
      else $error("level bit not captured");
   a_nor_p3p0: assert property (@(posedge mclk) disable iff (sys_rst)   // R9
      (src == 3'h5 && !level && p3_in[3:1] == 3'h0 && !p0_in[0] && !p0_in[7] && !wr_select)
      |=> !hit)
      else $error("nor mode wrong");
   a_excl_pin: assert property (@(posedge mclk) disable iff (sys_rst)   // R5
      (src == 3'h3 && level && (p3_sel[3:1] == 3'h7) && !wr_select && !wr_p3sel) |=> hit)
      else $error("excluded pins not ignored");
   a_wake_ends: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      (state == SWL_STOP && any_wake) |=> (recovery && state == SWL_WAKE) ##1 !stop_mode)
      else $error("stop not ended");
   a_sel_hold: assert property (@(posedge mclk) disable iff (sys_rst)   // R6
      (recovery && !$past(wr_p2sel)) |-> (p2_sel == $past(p2_sel)))
      else $error("selector lost on recovery");
   a_cfg_hold: assert property (@(posedge mclk) disable iff (sys_rst)   // R10
      !wr_select |=> $stable(src) && $stable(level))
      else $error("select register changed");
   a_hit_level: assert property (@(posedge mclk) disable iff (sys_rst)   // R3
      (src == 3'h2 && !level && p2_in == 8'hff && p2_out_en == 8'h00 && p2_sel == 8'h00
       && !wr_select && !wr_p2sel) |=> hit)
      else $error("equal compare wrong");

   // Register port: read data for one cycle after the strobe, zero otherwise
   a_rdata_idle: assert property (@(posedge mclk) disable iff (sys_rst)   // R7
      !reg_rd |=> (reg_rdata == 8'h00))
      else $error("read data not zero when idle");

   a_select_rd: assert property (@(posedge mclk) disable iff (sys_rst)   // R7
      (reg_rd && reg_addr == SWL_ADDR_SELECT) |=> (reg_rdata == 8'h00))
      else $error("write-only register read nonzero");

   a_status_rd: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      (reg_rd && reg_addr == SWL_ADDR_STATUS) |=> (reg_rdata == {6'h00, $past(status)}))
      else $error("status read wrong");

   a_enable_rd: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      (reg_rd && reg_addr == SWL_ADDR_ENABLE) |=> (reg_rdata == {6'h00, $past(irq_en)}))
      else $error("enable read wrong");

   // Selector and enable capture; selectors keep their value otherwise
   a_p2sel_capture: assert property (@(posedge mclk) disable iff (sys_rst)   // R6
      wr_p2sel |=> (p2_sel == $past(reg_wdata)))
      else $error("port 2 selector not captured");

   a_p3sel_capture: assert property (@(posedge mclk) disable iff (sys_rst)   // R5
      wr_p3sel |=> (p3_sel == $past(reg_wdata[3:0])))
      else $error("port 3 selector not captured");

   a_p2sel_hold: assert property (@(posedge mclk) disable iff (sys_rst)   // R6
      !wr_p2sel |=> $stable(p2_sel))
      else $error("port 2 selector changed");

   a_p3sel_hold: assert property (@(posedge mclk) disable iff (sys_rst)   // R5
      !wr_p3sel |=> $stable(p3_sel))
      else $error("port 3 selector changed");

   a_irq_en_capture: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      wr_enable |=> (irq_en == $past(reg_wdata[1:0])))
      else $error("interrupt enable not captured");

   // Mode functions with all pins taking part, and the unused code
   a_mode_unused: assert property (@(posedge mclk) disable iff (sys_rst)   // R1
      (src == 3'h7) |=> !hit)
      else $error("hit with unused source code");

   a_hit_needs_src: assert property (@(posedge mclk) disable iff (sys_rst)   // R2
      hit |-> ($past(src) != 3'h0))
      else $error("hit without a source");

   a_nand_p2lo: assert property (@(posedge mclk) disable iff (sys_rst)   // R9
      (src == 3'h1 && level && p2_in[3:0] == 4'h0 && (p2_out_en[3:0] | p2_sel[3:0]) == 4'h0)
      |=> hit)
      else $error("nand of low port 2 pins wrong");

   a_nand_p2all: assert property (@(posedge mclk) disable iff (sys_rst)   // R9
      (src == 3'h2 && level && p2_in == 8'h00 && (p2_out_en | p2_sel) == 8'h00)
      |=> hit)
      else $error("nand of port 2 pins wrong");

   a_nor_p3: assert property (@(posedge mclk) disable iff (sys_rst)   // R9
      (src == 3'h3 && level && p3_in[3:1] == 3'h0) |=> hit)
      else $error("nor of port 3 pins wrong");

   a_nand_p3: assert property (@(posedge mclk) disable iff (sys_rst)   // R9
      (src == 3'h4 && !level && p3_in[3:1] == 3'h7) |=> hit)
      else $error("nand of port 3 pins wrong");

   a_nand_p3p0: assert property (@(posedge mclk) disable iff (sys_rst)   // R9
      (src == 3'h6 && !level && p3_in[3:1] == 3'h7 && p0_in[0] && p0_in[7])
      |=> hit)
      else $error("nand of port 3 and port 0 pins wrong");

   a_nor_p3p0_hi: assert property (@(posedge mclk) disable iff (sys_rst)   // R9
      (src == 3'h5 && level && p3_in[3:1] == 3'h0 && !p0_in[0] && !p0_in[7])
      |=> hit)
      else $error("nor of port 3 and port 0 pins wrong");

   // Excluded pins take the gate's neutral value
   a_excl_out: assert property (@(posedge mclk) disable iff (sys_rst)   // R5
      (src == 3'h4 && !level && p3_out_en[3:1] == 3'h7) |=> hit)
      else $error("output pins not ignored");

   a_excl_p2: assert property (@(posedge mclk) disable iff (sys_rst)   // R5
      (src == 3'h2 && !level && (p2_out_en | p2_sel) == 8'hff) |=> hit)
      else $error("port 2 excluded pins not ignored");

   a_excl_p0: assert property (@(posedge mclk) disable iff (sys_rst)   // R5
      (src == 3'h5 && level && p3_in[3:1] == 3'h0 && p0_out_en[0] && p0_out_en[7])
      |=> hit)
      else $error("port 0 output pins not ignored");

   // Stop sequencing
   a_stop_entry: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      (state == SWL_RUN && stop_req) |=> (stop_mode && state == SWL_STOP))
      else $error("stop not entered");

   a_stop_stays: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      (state == SWL_STOP && !any_wake) |=> (stop_mode && !recovery))
      else $error("stop left without a source");

   a_rec_pulse: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      recovery |=> !recovery)
      else $error("recovery longer than one cycle");

   a_run_no_rec: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      (state != SWL_STOP) |=> !recovery)
      else $error("recovery outside stop");

   // Sticky status and interrupt level
   a_wake_status: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      ev_wake |=> status[SWL_ST_WAKE])
      else $error("wake status not set");

   a_logic_status: assert property (@(posedge mclk) disable iff (sys_rst)   // R3
      ev_logic |=> status[SWL_ST_LOGIC])
      else $error("logic status not set");

   a_status_clear: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      (wr_clear && reg_wdata[SWL_ST_WAKE] && !ev_wake) |=> !status[SWL_ST_WAKE])
      else $error("wake status not cleared");

   a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)   // R8
      irq == |(status & irq_en))
      else $error("interrupt level wrong");
endmodule

// ---- common/swl_pkg.sv ----
package swl_pkg;
   // Register map and field layout
   localparam logic [11:0] SWL_ADDR_SELECT = 12'hf0d;   // Wake logic select
   localparam logic [11:0] SWL_ADDR_STATUS = 12'hf10;   // Sticky wake status, read only
   localparam logic [11:0] SWL_ADDR_CLEAR  = 12'hf11;   // Write one to clear status
   localparam logic [11:0] SWL_ADDR_ENABLE = 12'hf12;   // Interrupt enable
   localparam logic [11:0] SWL_ADDR_CTRL   = 12'hf13;   // Port 2 selector
   localparam logic [11:0] SWL_ADDR_PORT3  = 12'hf14;   // Port 3 selector
   localparam int          SWL_LEVEL_BIT   = 6;
   localparam int          SWL_SRC_HI      = 4;
   localparam int          SWL_SRC_LO      = 2;
   localparam logic [2:0]  SWL_SRC_RESET   = 3'h0;
   localparam logic        SWL_LEVEL_RESET = 1'h0;
   localparam logic [7:0]  SWL_P2SEL_RESET = 8'h00;
   localparam logic [3:0]  SWL_P3SEL_RESET = 4'h0;
   localparam logic [1:0]  SWL_STAT_RESET  = 2'h0;
   // Status bits: 0 wake event seen, 1 source-register hit
   localparam int          SWL_ST_WAKE     = 0;
   localparam int          SWL_ST_LOGIC    = 1;
   // Source encodings
   typedef enum logic [2:0] {
      SWL_SRC_NONE       = 3'h0,
      SWL_SRC_NAND_P2LO  = 3'h1,
      SWL_SRC_NAND_P2ALL = 3'h2,
      SWL_SRC_NOR_P3     = 3'h3,
      SWL_SRC_NAND_P3    = 3'h4,
      SWL_SRC_NOR_P3P0   = 3'h5,
      SWL_SRC_NAND_P3P0  = 3'h6
   } swl_src_t;
   // Sequencer states
   typedef enum logic [2:0] {
      SWL_RUN   = 3'b001,
      SWL_STOP  = 3'b010,
      SWL_WAKE  = 3'b100
   } swl_state_t;
endpackage

// ---- rtl/swl_eval.sv ----
`timescale 1ns/1ps
// Combinational wake function, registered once
module swl_eval
   import swl_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] src,
   input  wire logic       level,
   input  wire logic [7:0] p0_in,
   input  wire logic [7:0] p2_in,
   input  wire logic [3:0] p3_in,
   input  wire logic [7:0] p0_out_en,
   input  wire logic [7:0] p2_out_en,
   input  wire logic [3:0] p3_out_en,
   input  wire logic [7:0] p2_sel,
   input  wire logic [3:0] p3_sel,
   output logic            hit
);
   // Excluded pins are forced to the function's neutral value
   wire logic [7:0] p2_ex = p2_out_en | p2_sel;   // R5
   wire logic [3:0] p3_ex = p3_out_en | p3_sel;   // R5
   wire logic       p0_0_ex = p0_out_en[0];
   wire logic       p0_7_ex = p0_out_en[7];
   // NAND neutral is 1, NOR neutral is 0
   wire logic [7:0] p2_and = p2_in | p2_ex;
   wire logic [3:1] p3_and = p3_in[3:1] | p3_ex[3:1];
   wire logic [3:1] p3_or  = p3_in[3:1] & ~p3_ex[3:1];
   wire logic       p00_and = p0_in[0] | p0_0_ex;
   wire logic       p07_and = p0_in[7] | p0_7_ex;
   wire logic       p00_or  = p0_in[0] & ~p0_0_ex;
   wire logic       p07_or  = p0_in[7] & ~p0_7_ex;
   logic            func;
   logic            valid;
   // Six modes over fixed pin groups, plus code zero for no source
   always_comb begin   // R1 R9
      func  = 1'b0;
      valid = 1'b1;
      case (swl_src_t'(src))
         SWL_SRC_NONE:       valid = 1'b0;   // R2
         SWL_SRC_NAND_P2LO:  func = ~&p2_and[3:0];
         SWL_SRC_NAND_P2ALL: func = ~&p2_and;
         SWL_SRC_NOR_P3:     func = ~|p3_or;
         SWL_SRC_NAND_P3:    func = ~&p3_and;
         SWL_SRC_NOR_P3P0:   func = ~(|p3_or | p00_or | p07_or);
         SWL_SRC_NAND_P3P0:  func = ~(&p3_and & p00_and & p07_and);
         default:            valid = 1'b0;
      endcase
   end
   // Equality with level raises the hit
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hit <= 1'b0;
      end else begin
         hit <= valid & (func == level);   // R3 R4
      end
   end
endmodule

// ---- tb/swl_pins.sv ----
`timescale 1ns/1ps
// Port pin model: levels and output enables, changed only on load or reset
module swl_pins (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        load,
   input  wire logic [39:0] val,
   output logic      [7:0]  p0_in,
   output logic      [7:0]  p2_in,
   output logic      [3:0]  p3_in,
   output logic      [7:0]  p0_out_en,
   output logic      [7:0]  p2_out_en,
   output logic      [3:0]  p3_out_en
);
   // Registered so pins move in the edge's own time step only after that edge's sampling
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         {p3_out_en, p2_out_en, p0_out_en, p3_in, p2_in, p0_in} <= 40'h0;
      end else if (load) begin
         {p3_out_en, p2_out_en, p0_out_en, p3_in, p2_in, p0_in} <= val;
      end
   end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top import swl_pkg::*;;
   logic        mclk, sys_rst, reg_wr, reg_rd, stop_req, other_wake, load, stop_mode, recovery, irq, ex;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rd, p0_in, p2_in, p0_out_en, p2_out_en, s2, sel, x;
   logic [3:0]  p3_in, p3_out_en, s3;
   logic [39:0] val;
   int          bad_count, total_checks, seed, n, en;
   swl_top i_swl_top (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p0_in(p0_in), .p2_in(p2_in),
      .p3_in(p3_in), .p0_out_en(p0_out_en), .p2_out_en(p2_out_en), .p3_out_en(p3_out_en),
      .stop_req(stop_req), .other_wake(other_wake), .stop_mode(stop_mode), .recovery(recovery), .irq(irq));
   swl_pins i_swl_pins (.mclk(mclk), .sys_rst(sys_rst), .load(load), .val(val), .p0_in(p0_in),
      .p2_in(p2_in), .p3_in(p3_in), .p0_out_en(p0_out_en), .p2_out_en(p2_out_en), .p3_out_en(p3_out_en));
   // Reference wake decision; excluded pins take the gate's neutral value
   function automatic logic wake(input logic [7:0] c, input logic [39:0] v, input logic [7:0] t2,
                                 input logic [3:0] t3);
      logic [7:0] m2;
      logic [3:0] m3;
      logic [4:0] g, m;
      logic       o;
      m2 = ~(v[35:28] | t2);
      m3 = ~(v[39:36] | t3);
      g = {v[19:17], v[0], v[7]};
      m = {m3[3:1], ~v[20], ~v[27]};
      case (c[4:2])
         3'h1: o = ~&(v[11:8] | ~m2[3:0]);
         3'h2: o = ~&(v[15:8] | ~m2);
         3'h3: o = ~|(g[4:2] & m[4:2]);
         3'h4: o = ~&(g[4:2] | ~m[4:2]);
         3'h5: o = ~|(g & m);
         3'h6: o = ~&(g | ~m);
         default: return 1'b0;
      endcase
      return o == c[6];
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdt(input logic [11:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // Counts recovery pulses over a short window, starting in the current cycle
   task automatic win();
      n = 0;
      repeat (8) begin
         #1 if (recovery === 1'b1) n++;
         @(posedge mclk);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Clock, 5 ns period
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Hang guard, far beyond the expected run
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      test_done();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, stop_req, other_wake, load} = 6'b100000;
      {reg_addr, reg_wdata, val, sel} = 68'h0;
      seed = 32'hbd7f;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 48; i++) begin
         // First pass runs on reset values; later passes keep or rewrite
         if (i > 0 && $random(seed) % 2 == 0) begin
            x = 8'($random(seed));
            sel = {1'b0, x[6:0]};
            wr(SWL_ADDR_SELECT, sel);
         end
         s2 = 8'($random(seed) & $random(seed));
         s3 = 4'($random(seed) & $random(seed));
         en = $random(seed) & 1;
         wr(SWL_ADDR_CTRL, s2);
         wr(SWL_ADDR_PORT3, {4'h0, s3});
         wr(SWL_ADDR_ENABLE, 8'(en));
         @(posedge mclk);
         val <= 40'({$random(seed), $random(seed)});
         load <= 1'b1;
         @(posedge mclk);
         load <= 1'b0;
         repeat (4) @(posedge mclk);
         ex = wake(sel, val, s2, s3);
         stop_req <= 1'b1;
         @(posedge mclk);
         stop_req <= 1'b0;
         #1 chk("stop_entry", 8'h1, {7'h0, stop_mode});
         win();
         chk("pin_wake", 8'(ex), 8'(n));
         if (n == 0) begin
            other_wake <= 1'b1;
            @(posedge mclk);
            other_wake <= 1'b0;
            win();
            chk("other_wake", 8'h1, 8'(n));
         end
         #1 chk("stop_mode", 8'h0, {7'h0, stop_mode});
         rdt(SWL_ADDR_STATUS);
         chk("status_wake", 8'h1, {7'h0, rd[SWL_ST_WAKE]});
         chk("irq_set", 8'(en), {7'h0, irq});
         rdt(SWL_ADDR_ENABLE);
         chk("enable_read", 8'(en), rd);
         wr(SWL_ADDR_CLEAR, 8'h03);
         repeat (2) @(posedge mclk);
         #1 chk("irq_clear", 8'h0, {7'h0, irq});
      end
      rdt(SWL_ADDR_SELECT);
      chk("select_read", 8'h0, rd);
      rdt(12'hf00);
      chk("unmapped_read", 8'h0, rd);
      test_done();
   end
endmodule
